//--- design/sfsr_front.sv
/*
  Serial flash command front end: write-enable latch, status registers,
  status write timing, plain read streaming, identify and security addressing.
  Assumes the host drives chip select, clock and serial input asynchronously to
  i_sys_clk with a bus clock at most an eighth of the system rate; the array
  engine and memory live outside on the same system clock.
*/
// Functional notes
// - write-enable opcode sets the write-enable latch
// - program, erase, security program/erase need latch set; status write needs latch or volatile enable
// - write-disable opcode clears the write-enable latch
// - latch cleared at reset and when any write or array operation completes
// - volatile enable keeps latch, qualifies only the next status write
// - status reads shift selected register out MSB first on falling edges
// - status reads allowed anytime, repeat until chip select rises
// - status write touches only bits 7..2, 14..11, 9 and 8, others read-only
// - security lock bits never return to zero once set, until reset
// - non-volatile status write needs write-enable beforehand, else rejected
// - volatile status write keeps latch zero, cannot lower lock or protect-b
// - status write must end after 8th or 16th data bit, else discarded
// - status write ending after one byte clears complement, quad, and protect-b if latch set
// - non-volatile status write holds busy for timed cycle, then clears latch
// - volatile status write applies within refresh time, busy stays zero
// - all status bits default to zero
// - plain read: opcode plus 24-bit address, data MSB first on falls
// - plain read advances address per byte until chip select rises
// - plain read while busy is ignored and leaves the cycle alone
// - identify: after three dummy bytes device code repeats until deselect
// - security address: upper 00h, middle 10h/20h/30h, low byte offset
// - command starts at chip select fall; first byte MSB first is opcode
// - write, program, erase ignored unless deselect on byte boundary
// - while busy only status reads are accepted
`default_nettype none
module sfsr_front #(
  parameter int WRSR_CYCLES = sfsr_pkg::WRSR_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // serial bus pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // memory read port, data valid the cycle after o_mem.rd
  output sfsr_pkg::sfsr_mem_t o_mem,
  input wire logic [7:0] i_mem_data,
  // array engine port
  output sfsr_pkg::sfsr_op_t o_op,
  input wire logic i_array_busy,
  input wire logic i_array_done
);

  typedef struct packed {
    sfsr_pkg::sfsr_state_t state;
    logic cs_s1, cs_s2, cs_d;
    logic sck_s1, sck_s2, sck_d;
    logic si_s1, si_s2;
    logic [7:0] cmd;
    logic [7:0] in_sr;
    logic [2:0] bitcnt;
    logic [2:0] bytecnt;
    logic [23:0] addr;
    logic [1:0] scr;
    logic [7:0] out_sr;
    logic [2:0] obit;
    logic [7:0] pre;
    logic rd_pend;
    logic so;
    logic so_oe;
    logic [15:0] status;
    logic write_enable_latch;
    logic vol_en;
    logic wrsr_busy;
    logic [23:0] wcnt;
    logic vol_pend;
    logic [7:0] vcnt;
    logic [15:0] new_val;
    sfsr_pkg::sfsr_mem_t mem;
    sfsr_pkg::sfsr_op_t op;
  } sfsr_front_t;

  sfsr_front_t st;
  sfsr_front_t next_st;

  // security register select from the upper two address bytes, 0 when not a match
  function automatic logic [1:0] sfsr_scr_sel(input logic [23:0] a);
    logic [1:0] r;
    r = 2'h0;
    if (a[23:16] == sfsr_pkg::SCR_UPPER) begin
      if (a[15:8] == sfsr_pkg::SCR_MID_1) r = 2'h1;
      else if (a[15:8] == sfsr_pkg::SCR_MID_2) r = 2'h2;
      else if (a[15:8] == sfsr_pkg::SCR_MID_3) r = 2'h3;
    end
    return r;
  endfunction

  logic busy;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic [7:0] byte_in;
  logic [23:0] addr_in;
  logic [15:0] wr_data;
  logic [15:0] wr_val;
  logic [7:0] src;
  logic is_write;
  logic is_prog;

  // edges come from the second and third stage only; stage one feeds stage two alone
  always_comb begin
    busy = st.wrsr_busy | i_array_busy;
    sck_rise = st.sck_s2 & ~st.sck_d & ~st.cs_s2;
    sck_fall = ~st.sck_s2 & st.sck_d & ~st.cs_s2;
    cs_fall = ~st.cs_s2 & st.cs_d;
    cs_rise = st.cs_s2 & ~st.cs_d;
    byte_in = {st.in_sr[6:0], st.si_s2};
    addr_in = {st.addr[15:0], byte_in};
    is_prog = (st.cmd == sfsr_pkg::OP_PP) | (st.cmd == sfsr_pkg::OP_QPP) | (st.cmd == sfsr_pkg::OP_SCR_PG);
    is_write = (byte_in == sfsr_pkg::OP_PP) | (byte_in == sfsr_pkg::OP_QPP) | (byte_in == sfsr_pkg::OP_SCR_PG)
      | (byte_in == sfsr_pkg::OP_SE) | (byte_in == sfsr_pkg::OP_BE32) | (byte_in == sfsr_pkg::OP_BE64)
      | (byte_in == sfsr_pkg::OP_SCR_ER) | (byte_in == sfsr_pkg::OP_CE_A) | (byte_in == sfsr_pkg::OP_CE_B);
    // status write data: one byte leaves the high half at its locks only
    wr_data = (st.bytecnt == 3'h1) ? {st.status[15:8] & sfsr_pkg::LOCK_MASK[15:8], st.addr[7:0]}
      : {st.addr[7:0], st.addr[15:8]};
    wr_val = (st.status & ~sfsr_pkg::WR_MASK) | (wr_data & sfsr_pkg::WR_MASK);
    wr_val = wr_val | (st.status & sfsr_pkg::LOCK_MASK);
    if (!st.write_enable_latch) begin
      wr_val[sfsr_pkg::BIT_PROT_B] = wr_val[sfsr_pkg::BIT_PROT_B] | st.status[sfsr_pkg::BIT_PROT_B];
    end
    // output byte source; status is read live so busy is current at each byte load
    case (st.cmd)
      sfsr_pkg::OP_RDSR_LO: src = {st.status[7:2], st.write_enable_latch, busy};
      sfsr_pkg::OP_RDSR_HI: src = st.status[15:8];
      sfsr_pkg::OP_ID: src = sfsr_pkg::DEVICE_CODE;
      default: src = st.pre;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.cs_s1 = i_cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.cs_d = st.cs_s2;
    next_st.sck_s1 = i_sck;
    next_st.sck_s2 = st.sck_s1;
    next_st.sck_d = st.sck_s2;
    next_st.si_s1 = i_si;
    next_st.si_s2 = st.si_s1;
    next_st.mem.rd = 1'b0;
    next_st.op.start = 1'b0;
    next_st.op.wvalid = 1'b0;
    next_st.rd_pend = st.mem.rd;
    if (st.rd_pend) next_st.pre = i_mem_data;

    // background cycles; a new command cannot collide since busy blocks it
    if (i_array_done) next_st.write_enable_latch = 1'b0;
    if (st.wrsr_busy) begin
      if (st.wcnt == 24'h0) begin
        next_st.wrsr_busy = 1'b0;
        next_st.write_enable_latch = 1'b0;
        next_st.status = st.new_val;
      end else begin
        next_st.wcnt = st.wcnt - 24'h1;
      end
    end
    if (st.vol_pend) begin
      if (st.vcnt == 8'h0) begin
        next_st.vol_pend = 1'b0;
        next_st.status = st.new_val;
      end else begin
        next_st.vcnt = st.vcnt - 8'h1;
      end
    end

    if (cs_fall) begin
      next_st.state = sfsr_pkg::S_OPC;
      next_st.bitcnt = 3'h0;
      next_st.bytecnt = 3'h0;
      next_st.obit = 3'h0;
      next_st.so_oe = 1'b0;
    end else if (cs_rise) begin
      next_st.so_oe = 1'b0;
      next_st.state = sfsr_pkg::S_IGN;
      case (st.state)
        sfsr_pkg::S_HOLD: begin
          if (st.bitcnt == 3'h0) begin
            case (st.cmd)
              sfsr_pkg::OP_WREN: next_st.write_enable_latch = 1'b1;
              sfsr_pkg::OP_WRDI: next_st.write_enable_latch = 1'b0;
              sfsr_pkg::OP_WREN_VOL: next_st.vol_en = 1'b1;
              default: next_st.op.start = 1'b1;
            endcase
          end
        end
        sfsr_pkg::S_WDATA: begin
          if (st.bitcnt == 3'h0 && st.bytecnt == 3'h4) next_st.op.start = 1'b1;
        end
        sfsr_pkg::S_WRSR: begin
          next_st.vol_en = 1'b0;
          // only the 8th or 16th data bit ends it properly
          if (st.bitcnt == 3'h0 && (st.bytecnt == 3'h1 || st.bytecnt == 3'h2)) begin
            next_st.new_val = wr_val;
            if (st.write_enable_latch) begin
              next_st.wrsr_busy = 1'b1;
              next_st.wcnt = 24'(WRSR_CYCLES - 1);
            end else begin
              next_st.vol_pend = 1'b1;
              next_st.vcnt = 8'(sfsr_pkg::VOL_CYCLES - 1);
            end
          end
        end
        default: next_st.state = sfsr_pkg::S_IGN;
      endcase
    end else if (sck_rise) begin
      next_st.in_sr = byte_in;
      next_st.bitcnt = st.bitcnt + 3'h1;
      if (st.bitcnt == 3'h7) begin
        case (st.state)
          sfsr_pkg::S_OPC: begin
            next_st.cmd = byte_in;
            if (byte_in != sfsr_pkg::OP_WRSR) next_st.vol_en = 1'b0;
            if (busy && byte_in != sfsr_pkg::OP_RDSR_LO && byte_in != sfsr_pkg::OP_RDSR_HI) begin
              next_st.state = sfsr_pkg::S_IGN;
            end else if (is_write && !st.write_enable_latch) begin
              next_st.state = sfsr_pkg::S_IGN;
            end else begin
              case (byte_in)
                sfsr_pkg::OP_WREN, sfsr_pkg::OP_WRDI, sfsr_pkg::OP_WREN_VOL,
                sfsr_pkg::OP_CE_A, sfsr_pkg::OP_CE_B: next_st.state = sfsr_pkg::S_HOLD;
                sfsr_pkg::OP_RDSR_LO, sfsr_pkg::OP_RDSR_HI: next_st.state = sfsr_pkg::S_OUT;
                sfsr_pkg::OP_WRSR: begin
                  next_st.state = (st.write_enable_latch || st.vol_en) ? sfsr_pkg::S_WRSR
                    : sfsr_pkg::S_IGN;
                end
                sfsr_pkg::OP_READ, sfsr_pkg::OP_ID, sfsr_pkg::OP_SCR_RD,
                sfsr_pkg::OP_PP, sfsr_pkg::OP_QPP, sfsr_pkg::OP_SCR_PG,
                sfsr_pkg::OP_SE, sfsr_pkg::OP_BE32, sfsr_pkg::OP_BE64,
                sfsr_pkg::OP_SCR_ER: next_st.state = sfsr_pkg::S_ADDR;
                default: next_st.state = sfsr_pkg::S_IGN;
              endcase
            end
          end
          sfsr_pkg::S_ADDR: begin
            next_st.addr = addr_in;
            next_st.bytecnt = st.bytecnt + 3'h1;
            next_st.scr = sfsr_scr_sel(addr_in);
            next_st.op.code = st.cmd;
            next_st.op.addr = addr_in;
            next_st.op.scr = sfsr_scr_sel(addr_in);
            if (st.bytecnt == 3'h2) begin
              case (st.cmd)
                sfsr_pkg::OP_READ: begin
                  next_st.scr = 2'h0;
                  next_st.mem.rd = 1'b1;
                  next_st.mem.scr = 2'h0;
                  next_st.mem.addr = addr_in;
                  next_st.state = sfsr_pkg::S_OUT;
                end
                sfsr_pkg::OP_ID: next_st.state = sfsr_pkg::S_OUT;
                sfsr_pkg::OP_SCR_RD, sfsr_pkg::OP_SCR_PG, sfsr_pkg::OP_SCR_ER: begin
                  if (sfsr_scr_sel(addr_in) == 2'h0) next_st.state = sfsr_pkg::S_IGN;
                  else if (st.cmd == sfsr_pkg::OP_SCR_RD) next_st.state = sfsr_pkg::S_DUMMY;
                  else if (st.cmd == sfsr_pkg::OP_SCR_PG) next_st.state = sfsr_pkg::S_WDATA;
                  else next_st.state = sfsr_pkg::S_HOLD;
                end
                default: next_st.state = is_prog ? sfsr_pkg::S_WDATA : sfsr_pkg::S_HOLD;
              endcase
            end
          end
          sfsr_pkg::S_DUMMY: begin
            next_st.mem.rd = 1'b1;
            next_st.mem.scr = st.scr;
            next_st.mem.addr = st.addr;
            next_st.state = sfsr_pkg::S_OUT;
          end
          sfsr_pkg::S_WRSR: begin
            next_st.addr = {st.addr[15:0], byte_in};
            next_st.bytecnt = (st.bytecnt == 3'h3) ? 3'h3 : st.bytecnt + 3'h1;
          end
          sfsr_pkg::S_WDATA: begin
            // data bytes stream straight to the array engine's page buffer
            next_st.op.wvalid = 1'b1;
            next_st.op.wdata = byte_in;
            next_st.bytecnt = 3'h4;
          end
          sfsr_pkg::S_HOLD: next_st.state = sfsr_pkg::S_IGN;
          default: next_st.state = st.state;
        endcase
      end
    end else if (sck_fall && st.state == sfsr_pkg::S_OUT) begin
      // byte reload on a bit-count wrap makes status and id repeat forever
      next_st.so_oe = 1'b1;
      next_st.obit = st.obit + 3'h1;
      if (st.obit == 3'h0) begin
        next_st.so = src[7];
        next_st.out_sr = {src[6:0], 1'b0};
        if (st.cmd == sfsr_pkg::OP_READ || st.cmd == sfsr_pkg::OP_SCR_RD) begin
          next_st.addr = st.addr + 24'h1;
          next_st.mem.rd = 1'b1;
          next_st.mem.scr = st.scr;
          next_st.mem.addr = st.addr + 24'h1;
        end
      end else begin
        next_st.so = st.out_sr[7];
        next_st.out_sr = {st.out_sr[6:0], 1'b0};
      end
    end
  end

  // reset loads constants only: factory-zero status, latch clear, sync chain idle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
      st.state <= sfsr_pkg::S_IGN;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.cs_d <= 1'b1;
      st.status <= sfsr_pkg::STATUS_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_so = st.so;
  assign o_so_oe = st.so_oe;
  assign o_mem = st.mem;
  assign o_op = st.op;

endmodule
`default_nettype wire

//--- design/sfsr_pkg.sv
/*
  Shared constants and carrier types of the serial flash command front end.
  Assumes a 125 MHz system clock; all other timing derives from it.
*/
`default_nettype none
package sfsr_pkg;
  // system clock period
  localparam int CLK_NS = 8;
  // self-timed non-volatile status write duration
  localparam int WRSR_TIME_NS = 10000000;
  localparam int WRSR_CYCLES = WRSR_TIME_NS / CLK_NS;
  // volatile_refresh_time, longest allowed, rounded down
  localparam int VOL_REFRESH_NS = 50;
  localparam int VOL_CYCLES = (VOL_REFRESH_NS / CLK_NS) < 1 ? 1 : (VOL_REFRESH_NS / CLK_NS);

  // opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WREN_VOL = 8'h50;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR_LO = 8'h05;
  localparam logic [7:0] OP_RDSR_HI = 8'h35;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_ID = 8'hAB;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_QPP = 8'h32;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hD8;
  localparam logic [7:0] OP_CE_A = 8'hC7;
  localparam logic [7:0] OP_CE_B = 8'h60;
  localparam logic [7:0] OP_SCR_ER = 8'h44;
  localparam logic [7:0] OP_SCR_PG = 8'h42;
  localparam logic [7:0] OP_SCR_RD = 8'h48;

  // security register address decode
  localparam logic [7:0] SCR_UPPER = 8'h00;
  localparam logic [7:0] SCR_MID_1 = 8'h10;
  localparam logic [7:0] SCR_MID_2 = 8'h20;
  localparam logic [7:0] SCR_MID_3 = 8'h30;

  // status field positions (status_high occupies 15:8)
  localparam int BIT_BUSY = 0;
  localparam int BIT_WRITE_ENABLE_LATCH = 1;
  localparam int BIT_PROT_B = 8;
  localparam int BIT_QUAD_ENABLE = 9;
  localparam int BIT_PROTECT_COMPLEMENT = 14;
  localparam int BIT_SUSPEND = 15;
  localparam logic [15:0] WR_MASK = 16'h7BFC;     // bits 14..11, 9, 8, 7..2
  localparam logic [15:0] LOCK_MASK = 16'h3800;   // security_lock_bits
  localparam logic [15:0] SHORT_CLR = 16'h4300;   // complement, quad enable, protect b
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // device code returned by the identify command; value is arbitrary
  localparam logic [7:0] DEVICE_CODE = 8'h5A;

  // read request towards the memory array or security registers
  typedef struct packed {
    logic rd;
    logic [1:0] scr;      // 0 main array, 1..3 security register
    logic [23:0] addr;
  } sfsr_mem_t;

  // program / erase request towards the array engine
  typedef struct packed {
    logic start;
    logic [7:0] code;
    logic [1:0] scr;
    logic [23:0] addr;
    logic wvalid;
    logic [7:0] wdata;
  } sfsr_op_t;

  typedef enum logic [7:0] {
    S_OPC = 8'h01,
    S_HOLD = 8'h02,
    S_ADDR = 8'h04,
    S_DUMMY = 8'h08,
    S_OUT = 8'h10,
    S_WRSR = 8'h20,
    S_WDATA = 8'h40,
    S_IGN = 8'h80
  } sfsr_state_t;
endpackage
`default_nettype wire

//--- tb/sfsr_host.sv
/*
  Bus host model: frames commands with chip select, 64 ns bus clock, mode 0.
  Assumes the caller leaves it idle between frames; clock parks low.
*/
`default_nettype none
module sfsr_host (
  // serial pins towards the device
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 1ps;
  // deselected and parked at time zero
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // one frame of nb bits, right aligned in tx; answer bits collect in rx
  task automatic frame(input logic [63:0] tx, input int nb, output logic [63:0] rx);
    rx = 64'h0;
    #3.5 o_cs_n = 1'b0;
    #32;
    for (int i = nb - 1; i >= 0; i--) begin
      o_si = tx[i]; // opcode first, msb first
      #32 rx = {rx[62:0], i_so};
      o_sck = 1'b1;
      #32 o_sck = 1'b0;
    end
    #32 o_cs_n = 1'b1; // frame length as the caller asks
    o_si = ~o_si; // released line shows no stale level
    #200;
  endtask
endmodule
`default_nettype wire

//--- tb/sfsr_monitor.sv
/*
  Port checker for the serial flash command front end, bound to its top.
  Assumes bus clock half periods of at least four system cycles.
*/
`default_nettype none
module sfsr_monitor #(
  parameter int WRSR_CYCLES = 20
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // serial pins
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic o_so,
  input wire logic o_so_oe,
  // memory and array engine
  input wire sfsr_pkg::sfsr_mem_t o_mem,
  input wire logic [7:0] i_mem_data,
  input wire sfsr_pkg::sfsr_op_t o_op,
  input wire logic i_array_busy,
  input wire logic i_array_done
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic cs_q; logic sck_q; logic seen; logic [23:0] last; logic [3:0] age;} sfsr_mon_t;
  sfsr_mon_t r;
  sfsr_mon_t next_r;
  // age of the last bus clock fall, last read address within the frame
  always_comb begin
    next_r = r;
    next_r.cs_q = i_cs_n;
    next_r.sck_q = i_sck;
    next_r.age = (r.age == 4'hF) ? r.age : r.age + 4'h1;
    if (r.sck_q && !i_sck) begin
      next_r.age = 4'h0;
    end
    if (r.cs_q && !i_cs_n) begin
      next_r.seen = 1'b0;
    end
    if (o_mem.rd) begin
      next_r.seen = 1'b1;
      next_r.last = o_mem.addr;
    end
  end
  // helper state register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence rd_req;
    o_mem.rd;
  endsequence
  sequence start_req;
    o_op.start;
  endsequence
  AST_OE_DROPS: assert property (i_cs_n [*6] |-> !o_so_oe)
    else $error("output enable high while deselected");
  AST_OE_RISE_IN_FRAME: assert property ($rose(o_so_oe) |-> !$past(i_cs_n, 4))
    else $error("output enable rose outside a frame");
  // the sync chain puts each new bit a few cycles after the pin fall
  AST_SO_ON_FALL: assert property ($changed(o_so) && o_so_oe && $past(o_so_oe) |-> r.age <= 4'h6)
    else $error("output bit changed away from a clock fall");
  AST_OE_HOLDS: assert property (o_so_oe && !i_cs_n |=> o_so_oe)
    else $error("output enable dropped inside a frame");
  AST_RD_IN_FRAME: assert property (rd_req |-> !i_array_busy && !$past(i_cs_n, 2))
    else $error("read request while busy or deselected");
  AST_RD_STEP: assert property (rd_req |-> !r.seen || o_mem.addr == r.last + 24'h1)
    else $error("read address did not advance by one");
  AST_RD_PULSE: assert property (rd_req |=> !o_mem.rd [*3])
    else $error("read request longer than one cycle");
  AST_START_AT_CS_RISE: assert property (start_req |-> i_cs_n && $past(i_cs_n))
    else $error("operation started inside a frame");
  AST_START_PULSE: assert property (start_req |=> !o_op.start [*4])
    else $error("operation start longer than one cycle");
  AST_START_IDLE: assert property (start_req |-> !i_array_busy)
    else $error("operation started while busy");
endmodule
bind sfsr_front sfsr_monitor #(.WRSR_CYCLES(WRSR_CYCLES)) sfsr_monitor_i (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .o_so(o_so),
  .o_so_oe(o_so_oe), .o_mem(o_mem), .i_mem_data(i_mem_data), .o_op(o_op), .i_array_busy(i_array_busy),
  .i_array_done(i_array_done));
`default_nettype wire

//--- tb/testbench.sv
/*
  Self-checking bench of the serial flash command front end.
  Assumes the host model drives the pins; memory and array engine are stand-ins.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [63:0] tx; int nb; int h; logic [31:0] ex;} sfsr_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  sfsr_pkg::sfsr_mem_t mem;
  sfsr_pkg::sfsr_op_t op;
  logic [7:0] mem_data = 8'h00;
  logic arr_busy = 1'b0;
  logic arr_done = 1'b0;
  logic [7:0] op_code = 8'h00;
  logic [23:0] op_addr = 24'h0;
  logic [7:0] op_wdata = 8'h00;
  logic [63:0] rx;
  int busy_left = 0;
  int starts = 0;
  int rds = 0;
  int fail_count = 0;
  int check_count = 0;
  int n;
  int r0;
  // status, volatile, read and identify frames with expected answers
  sfsr_row_t rows[27] = '{
    '{64'h050000, 24, 8, 32'h0}, '{64'h350000, 24, 8, 32'h0}, '{64'h06, 8, 8, 32'h0},
    '{64'h050000, 24, 8, 32'h0202}, '{64'h04, 8, 8, 32'h0}, '{64'h050000, 24, 8, 32'h0},
    '{64'h01FFFF, 24, 24, 32'h0}, '{64'h50, 8, 8, 32'h0}, '{64'h04, 8, 8, 32'h0},
    '{64'h01FFFF, 24, 24, 32'h0}, '{64'h50, 8, 8, 32'h0}, '{64'h01FFF, 20, 20, 32'h0},
    '{64'h350000, 24, 8, 32'h0}, '{64'h050000, 24, 8, 32'h0}, '{64'h50, 8, 8, 32'h0},
    '{64'h01FFFF, 24, 24, 32'h0}, '{64'h050000, 24, 8, 32'hFCFC}, '{64'h350000, 24, 8, 32'h7B7B},
    '{64'h50, 8, 8, 32'h0}, '{64'h010000, 24, 24, 32'h0}, '{64'h050000, 24, 8, 32'h0},
    '{64'h350000, 24, 8, 32'h3939}, '{64'h030000FF00000000, 64, 32, 32'h5AA5A4A7},
    '{64'h480010070000, 48, 40, 32'hE2}, '{64'h480020070000, 48, 40, 32'h22},
    '{64'h480030070000, 48, 40, 32'h62}, '{64'hAB00000000000000, 64, 32, {4{sfsr_pkg::DEVICE_CODE}}}};
  always #4 i_sys_clk = ~i_sys_clk;
  sfsr_front #(.WRSR_CYCLES(2000)) sfsr_front_i (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .o_so(so),
    .o_so_oe(so_oe), .o_mem(mem), .i_mem_data(mem_data), .o_op(op), .i_array_busy(arr_busy),
    .i_array_done(arr_done));
  sfsr_host sfsr_host_i (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));
  // memory answers the cycle after a request; array engine stays busy 1000 cycles
  always @(posedge i_sys_clk) begin
    mem_data <= mem.addr[7:0] ^ 8'hA5 ^ {mem.scr, 6'h00};
    rds <= rds + int'(mem.rd);
    if (op.wvalid) op_wdata <= op.wdata;
    arr_done <= 1'b0;
    if (op.start) begin
      starts <= starts + 1;
      op_code <= op.code;
      op_addr <= op.addr;
      arr_busy <= 1'b1;
      busy_left <= 1000;
    end else if (busy_left > 1) begin
      busy_left <= busy_left - 1;
    end else if (busy_left == 1) begin
      busy_left <= 0;
      arr_busy <= 1'b0;
      arr_done <= 1'b1;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic send(input logic [63:0] tx, input int nb);
    sfsr_host_i.frame(tx, nb, rx);
  endtask
  // last n answer bits of the frame just sent
  function automatic logic [31:0] tail(input int n);
    tail = rx[31:0] & ((32'h1 << n) - 32'h1);
  endfunction
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    check("idle outputs", {so_oe, mem.rd, op.start, so}, 32'h0);
    foreach (rows[k]) begin
      send(rows[k].tx, rows[k].nb);
      if (rows[k].h < rows[k].nb) check($sformatf("row %0d", k), tail(rows[k].nb - rows[k].h), rows[k].ex);
    end
    // single byte non-volatile write: busy first, value and cleared latch after
    send(64'h06, 8);
    send(64'h010C, 16);
    send(64'h050000, 24);
    check("busy bit", tail(16) & 32'h1, 32'h1);
    for (n = 0; n < 30 && rx[0] !== 1'b0; n++) send(64'h050000, 24);
    if (n == 30) begin
      check("busy end", 32'h1, 32'h0);
      wrap_up();
    end
    check("status low", tail(16), 32'h0C0C);
    send(64'h350000, 24);
    check("status high", tail(16), 32'h3838);
    // erase refused without latch and off a byte boundary, then taken
    send(64'h20123456, 32);
    send(64'h06, 8);
    send(64'h2012345, 28);
    check("starts", starts, 32'h0);
    send(64'h20123456, 32);
    check("starts", starts, 32'h1);
    check("op", {op_code, op_addr}, 32'h20123456);
    // while busy: disable and read ignored, status still answers
    r0 = rds;
    send(64'h04, 8);
    send(64'h03000010FFFF, 48);
    check("reads", rds, r0);
    send(64'h050000, 24);
    check("busy status", tail(16), 32'h0F0F);
    for (n = 0; n < 2000 && arr_busy; n++) @(posedge i_sys_clk);
    if (arr_busy) begin
      check("array done", 32'h1, 32'h0);
      wrap_up();
    end
    send(64'h050000, 24);
    check("after done", tail(16), 32'h0C0C);
    // reset in mid-run drops latch and all status, locks included
    send(64'h06, 8);
    @(posedge i_sys_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    send(64'h050000, 24);
    check("reset low", tail(16), 32'h0);
    send(64'h350000, 24);
    check("reset high", tail(16), 32'h0);
    // page program after reset: latch again, one data byte, start at deselect
    send(64'h06, 8);
    send(64'h02000010C3, 40);
    check("prog starts", starts, 32'h2);
    check("prog op", {op_code, op_addr}, 32'h02000010);
    check("prog data", op_wdata, 32'hC3);
    wrap_up();
  end
endmodule
`default_nettype wire
